// *** rtl/mbac_checker.sv ***
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "mbac_consts.svh"
module mbac_checker #(
	parameter int SEGS = 64
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [7:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte enables.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire mbac_pkg::mbac_mreq_s mreq_i, // CPU memory request.
	output mbac_pkg::mbac_mout_s mout_o, // Checked physical memory request.
	output logic mem_exc_o, // Denied memory access exception.
	input wire mbac_pkg::mbac_sreq_s sreq_i, // CPU register access request.
	output logic sfr_ok_o, // Register access granted.
	output logic sfr_exc_o // Denied register access exception.
);
	import mbac_pkg::*;

	function automatic logic in24(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in24 = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			lanes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	localparam int SW = $clog2(SEGS);

	mbac_mode_e mode_ff;
	logic [15:0] fwctrl_ff;
	logic [2:0] fmacc_ff;
	logic [SW-1:0] segsel_ff;
	logic [SW-1:0] act_ff;
	logic [1:0] seg_rt_ff [SEGS];
	logic [15:0] seg_hw_ff [SEGS];
	logic [23:0] seg_lo_ff [SEGS];
	logic [23:0] seg_hi_ff [SEGS];
	logic [23:0] seg_of_ff [SEGS];
	logic [255:0] prot_ff;
	logic [31:0] uwo_done_ff;
	logic deny_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	mbac_mout_s mout_ff;
	logic mexc_ff;
	logic sok_ff;
	logic sexc_ff;

	// Segment lookup; the lowest index wins when ranges overlap.
	logic seg_hit;
	logic [SW-1:0] seg_idx;
	always_comb begin
		seg_hit = 1'b0;
		seg_idx = '0;
		for (int i = SEGS - 1; i >= 0; i--) begin
			if (seg_rt_ff[i] != 2'b00 && in24(mreq_i.vaddr, seg_lo_ff[i], seg_hi_ff[i])) begin
				seg_hit = 1'b1;
				seg_idx = SW'(i);
			end
		end
	end

	wire is_user = (mode_ff == MODE_USER);
	wire is_sys = (mode_ff == MODE_SYS);
	// Outside user mode the map is flat, but every access still passes this unit.
	wire [23:0] paddr = is_user ? mreq_i.vaddr + seg_of_ff[seg_idx] : mreq_i.vaddr;
	wire seg_rw = seg_rt_ff[seg_idx][`MBAC_RT_RW];
	wire seg_x = seg_rt_ff[seg_idx][`MBAC_RT_X];

	wire r_rom = in24(paddr, `MBAC_ROM_LO, `MBAC_ROM_HI);
	wire r_rombl = in24(paddr, `MBAC_ROMBL_LO, `MBAC_ROM_HI);
	wire r_romfw = in24(paddr, `MBAC_ROMFW_LO, `MBAC_ROMFW_HI);
	wire r_sfl = in24(paddr, `MBAC_SFL_LO, `MBAC_SFL_HI);
	wire r_afl = in24(paddr, `MBAC_AFL_LO, `MBAC_AFL_HI);
	wire r_aflrom = in24(paddr, `MBAC_AFL_LO, `MBAC_AFLROM_HI);
	wire r_fee = in24(paddr, `MBAC_FEE_LO, `MBAC_FEE_HI);
	wire r_aee = in24(paddr, `MBAC_AEE_LO, `MBAC_AEE_HI);
	wire r_mfg = in24(paddr, `MBAC_MFG_LO, `MBAC_AEE_HI);
	wire r_fra = in24(paddr, `MBAC_FRA_LO, `MBAC_FRA_HI);
	wire r_ara = in24(paddr, `MBAC_ARA_LO, `MBAC_ARA_HI);
	wire [7:0] moff = paddr[7:0];
	wire m_uro = r_mfg && moff < `MBAC_M_UWP;
	wire m_uwp = r_mfg && moff >= `MBAC_M_UWP && moff < `MBAC_M_UWO;
	wire m_uwo = r_mfg && moff >= `MBAC_M_UWO && moff < `MBAC_M_VWP;
	wire m_vwp = r_mfg && moff >= `MBAC_M_VWP && moff < `MBAC_M_BL;
	wire m_bl = r_mfg && moff >= `MBAC_M_BL && moff < `MBAC_M_FUS;
	wire m_prb = r_mfg && moff >= `MBAC_M_PRB;
	wire m_vnib = r_mfg && moff == `MBAC_M_VNIB;
	// ROM cannot store, and only test mode may write the rominized flash; such writes are never forwarded.
	wire ro_mem = r_rom | (r_aflrom & (mode_ff != MODE_TEST));
	wire prot_bit = prot_ff[moff];
	wire uwo_used = m_uwo && uwo_done_ff[moff[4:0]];
	// System and user code may write plainly only the bootloader area of the manufacturer area.
	wire sys_mfg_wr = m_bl;
	wire app_mem = r_afl | r_aee | r_ara;

	logic rw_ok;
	logic x_ok;
	logic wr_mfg_ok;
	logic wo_ok;
	logic pw_ok;
	logic vfz_ok;
	logic vfp_ok;
	logic vez_ok;
	always_comb begin
		rw_ok = 1'b0;
		x_ok = 1'b0;
		wr_mfg_ok = 1'b0;
		wo_ok = 1'b0;
		pw_ok = 1'b0;
		vfz_ok = 1'b0;
		vfp_ok = 1'b0;
		vez_ok = 1'b0;
		case (mode_ff)
		MODE_BOOT: begin
			rw_ok = (r_rom & ~r_rombl) | r_sfl | r_fee | r_mfg | r_fra;
			x_ok = (r_rom & ~r_rombl) | r_sfl | r_mfg | r_fra;
			wr_mfg_ok = 1'b1;
			wo_ok = r_mfg;
			pw_ok = r_mfg;
		end
		MODE_TEST: begin
			rw_ok = r_rom | r_sfl | r_afl | r_fee | r_aee | r_fra | r_ara;
			x_ok = rw_ok & ~r_rombl;
			wr_mfg_ok = 1'b1;
			wo_ok = r_mfg;
			pw_ok = r_mfg;
			vfz_ok = r_afl;
			vfp_ok = r_afl;
			vez_ok = r_aee;
		end
		MODE_FW: begin
			rw_ok = r_romfw | r_sfl | r_fee | r_mfg | r_fra;
			x_ok = r_romfw | r_sfl | r_mfg | r_fra;
			wr_mfg_ok = m_bl;
			wo_ok = m_uwo;
			pw_ok = m_vwp;
			vfz_ok = r_afl & fmacc_ff[`MBAC_FM_VFZ];
			vfp_ok = r_afl & fmacc_ff[`MBAC_FM_VFP];
			vez_ok = r_aee & fmacc_ff[`MBAC_FM_VEZ];
		end
		MODE_SYS: begin
			rw_ok = app_mem;
			x_ok = app_mem;
			wr_mfg_ok = sys_mfg_wr;
			wo_ok = m_uwo && moff != `MBAC_M_NOWR;
			pw_ok = m_uwp | m_vnib;
			vfz_ok = r_afl;
			vfp_ok = r_afl;
			vez_ok = r_aee;
		end
		MODE_USER: begin
			rw_ok = app_mem & seg_hit & seg_rw;
			x_ok = app_mem & seg_hit & seg_x;
			wr_mfg_ok = sys_mfg_wr;
			wo_ok = m_uwo && moff != `MBAC_M_NOWR;
			pw_ok = m_uwp | m_vnib;
			vfz_ok = r_afl & rw_ok;
			vfp_ok = r_afl & rw_ok;
			vez_ok = r_aee & rw_ok;
		end
		default: begin
			rw_ok = 1'b0;
		end
		endcase
	end

	// Read and write share one data right; only physical storage and the manufacturer sub-areas split them.
	wire rd_ok = rw_ok;
	wire wr_ok = rw_ok & ~ro_mem & (~r_mfg | wr_mfg_ok);
	wire wo_gr = rw_ok & r_mfg & wo_ok & ~uwo_used;
	wire pw_gr = rw_ok & r_mfg & pw_ok & ~prot_bit;

	logic grant;
	always_comb begin
		case (mreq_i.op)
		OP_RD: grant = rd_ok;
		OP_WR: grant = wr_ok;
		OP_EX: grant = x_ok;
		OP_WO: grant = wo_gr;
		OP_PW: grant = pw_gr;
		OP_VFZ: grant = vfz_ok;
		OP_VFP: grant = vfp_ok;
		OP_VEZ: grant = vez_ok;
		default: grant = 1'b0;
		endcase
	end
	wire mgo = mreq_i.valid & grant;
	wire mbad = mreq_i.valid & ~grant;
	wire stores = mgo && (mreq_i.op == OP_WR || mreq_i.op == OP_WO || mreq_i.op == OP_PW);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mout_ff <= '0;
			mexc_ff <= 1'b0;
		end else begin
			mout_ff.valid <= mgo;
			mout_ff.op <= mreq_i.op;
			mout_ff.paddr <= paddr;
			mout_ff.wdata <= mreq_i.wdata;
			mout_ff.nib_only <= (is_sys | is_user) & m_vnib;
			mexc_ff <= mbad;
		end
	end

	// The protection bits and write-once marks shadow the stored area; they restart clear at reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prot_ff <= '0;
			uwo_done_ff <= '0;
			act_ff <= '0;
		end else begin
			if (stores && m_prb) begin
				prot_ff[{moff[4:0], 3'b000} +: 8] <= mreq_i.wdata;
			end
			if (mgo && mreq_i.op == OP_WO && m_uwo) begin
				uwo_done_ff[moff[4:0]] <= 1'b1;
			end
			if (mgo && is_user && mreq_i.op == OP_EX) begin
				act_ff <= seg_idx;
			end
		end
	end

	// Decode terms for six register groups; GRP_FWOS and GRP_TEST are compared inline below.
	wire g_mmu = sreq_i.grp == GRP_MMU;
	wire g_tonly = sreq_i.grp == GRP_TESTONLY;
	wire g_split = sreq_i.grp == GRP_CPUSPLIT;
	wire g_cpu = sreq_i.grp == GRP_CPU;
	wire g_hw = sreq_i.grp == GRP_HW;
	wire g_fwcfg = sreq_i.grp == GRP_FWCFG;
	wire hw_fw = fwctrl_ff[sreq_i.hw_idx];
	wire hw_usr = seg_rt_ff[act_ff] != 2'b00 && seg_hw_ff[act_ff][sreq_i.hw_idx];
	logic sfr_ok;
	always_comb begin
		case (mode_ff)
		MODE_BOOT: sfr_ok = ~(g_mmu | g_tonly | g_split);
		MODE_TEST: sfr_ok = ~(g_mmu | g_split);
		MODE_FW: sfr_ok = (g_fwcfg & ~sreq_i.write) | (sreq_i.grp == GRP_FWOS) | g_cpu | (g_hw & hw_fw);
		MODE_SYS: sfr_ok = ~(sreq_i.grp == GRP_FWOS || sreq_i.grp == GRP_TEST || g_tonly);
		MODE_USER: sfr_ok = g_cpu | g_split | (g_hw & hw_usr);
		default: sfr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sok_ff <= 1'b0;
			sexc_ff <= 1'b0;
		end else begin
			sok_ff <= sreq_i.valid & sfr_ok;
			sexc_ff <= sreq_i.valid & ~sfr_ok;
		end
	end

	// Register bus: one wait state, then a one-cycle acknowledge.
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire wb_wr = wb_req & wb_we_i;
	wire cfg_wr = wb_wr & is_sys;
	wire a_mode = wb_adr_i == `MBAC_REG_MODE;
	wire a_fwc = wb_adr_i == `MBAC_REG_FWCTRL;
	wire a_fma = wb_adr_i == `MBAC_REG_FMACC;
	wire a_sel = wb_adr_i == `MBAC_REG_SEGSEL;
	wire a_srt = wb_adr_i == `MBAC_REG_SEGRT;
	wire a_slo = wb_adr_i == `MBAC_REG_SEGLO;
	wire a_shi = wb_adr_i == `MBAC_REG_SEGHI;
	wire a_sof = wb_adr_i == `MBAC_REG_SEGOF;
	wire a_stat = wb_adr_i == `MBAC_REG_STAT;
	wire [31:0] old_rt = {seg_hw_ff[segsel_ff], 14'h0000, seg_rt_ff[segsel_ff]};
	wire [31:0] new_rt = lanes(old_rt, wb_dat_i, wb_sel_i);
	wire [31:0] new_lo = lanes({8'h00, seg_lo_ff[segsel_ff]}, wb_dat_i, wb_sel_i);
	wire [31:0] new_hi = lanes({8'h00, seg_hi_ff[segsel_ff]}, wb_dat_i, wb_sel_i);
	wire [31:0] new_of = lanes({8'h00, seg_of_ff[segsel_ff]}, wb_dat_i, wb_sel_i);
	wire [31:0] new_fw = lanes({16'h0000, fwctrl_ff}, wb_dat_i, wb_sel_i);
	wire [31:0] stat_v = {22'h00_0000, deny_ff, 6'(act_ff), mode_ff};
	wire deny_clr = wb_wr & a_stat & wb_sel_i[1] & wb_dat_i[`MBAC_STAT_DENY];

	logic [31:0] rdat;
	always_comb begin
		rdat = 32'h0000_0000;
		if (a_mode) rdat = {29'h0000_0000, mode_ff};
		if (a_fwc) rdat = {16'h0000, fwctrl_ff};
		if (a_fma) rdat = {29'h0000_0000, fmacc_ff};
		if (a_sel) rdat = 32'(segsel_ff);
		if (a_srt) rdat = old_rt;
		if (a_slo) rdat = {8'h00, seg_lo_ff[segsel_ff]};
		if (a_shi) rdat = {8'h00, seg_hi_ff[segsel_ff]};
		if (a_sof) rdat = {8'h00, seg_of_ff[segsel_ff]};
		if (a_stat) rdat = stat_v;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_req;
			rdat_ff <= wb_req ? rdat : rdat_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= MODE_BOOT;
			fwctrl_ff <= `MBAC_FWCTRL_RST;
			fmacc_ff <= `MBAC_FMACC_RST;
			segsel_ff <= '0;
			deny_ff <= 1'b0;
		end else begin
			if (wb_wr && a_mode && wb_sel_i[0] && !is_user && wb_dat_i[2:0] <= 3'(MODE_USER)) begin
				mode_ff <= mbac_mode_e'(wb_dat_i[2:0]);
			end
			if (cfg_wr && a_fwc) fwctrl_ff <= new_fw[15:0];
			if (cfg_wr && a_fma && wb_sel_i[0]) fmacc_ff <= wb_dat_i[2:0];
			if (cfg_wr && a_sel && wb_sel_i[0]) segsel_ff <= wb_dat_i[SW-1:0];
			// A denial in the clearing cycle keeps the flag set.
			deny_ff <= mbad | sexc_ff | (deny_ff & ~deny_clr);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < SEGS; i++) begin
				seg_rt_ff[i] <= 2'b00;
				seg_hw_ff[i] <= 16'h0000;
				seg_lo_ff[i] <= 24'h00_0000;
				seg_hi_ff[i] <= 24'h00_0000;
				seg_of_ff[i] <= 24'h00_0000;
			end
		end else begin
			if (cfg_wr && a_srt) begin
				seg_rt_ff[segsel_ff] <= new_rt[1:0];
				seg_hw_ff[segsel_ff] <= new_rt[31:16];
			end
			if (cfg_wr && a_slo) seg_lo_ff[segsel_ff] <= new_lo[23:0];
			if (cfg_wr && a_shi) seg_hi_ff[segsel_ff] <= new_hi[23:0];
			if (cfg_wr && a_sof) seg_of_ff[segsel_ff] <= new_of[23:0];
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign mout_o = mout_ff;
	assign mem_exc_o = mexc_ff;
	assign sfr_ok_o = sok_ff;
	assign sfr_exc_o = sexc_ff;

	property p_rw_pair;
		@(posedge clk_i) disable iff (rst_i) (!ro_mem && !r_mfg) |-> (rd_ok == wr_ok);
	endproperty
	a_rw_pair: assert property (p_rw_pair) else $error("read and write rights differ");

	property p_deny_block;
		@(posedge clk_i) disable iff (rst_i) mbad |=> (!mout_o.valid && mem_exc_o);
	endproperty
	a_deny_block: assert property (p_deny_block) else $error("denied access reached memory");

	property p_xlate;
		@(posedge clk_i) disable iff (rst_i)
			(mgo && is_user) |=> mout_o.paddr == 24'($past(mreq_i.vaddr) + $past(seg_of_ff[seg_idx]));
	endproperty
	a_xlate: assert property (p_xlate) else $error("user address not translated");

	property p_no_empty_seg;
		@(posedge clk_i) disable iff (rst_i) seg_hit |-> seg_rt_ff[seg_idx] != 2'b00;
	endproperty
	a_no_empty_seg: assert property (p_no_empty_seg) else $error("disabled segment matched");

	sequence s_sfr_deny;
		sreq_i.valid && !sfr_ok;
	endsequence
	sequence s_exc_pulse;
		sfr_exc_o && !sfr_ok_o;
	endsequence
	property p_sfr_exc;
		@(posedge clk_i) disable iff (rst_i) s_sfr_deny |=> s_exc_pulse ##1 (sfr_exc_o == $past(sreq_i.valid && !sfr_ok));
	endproperty
	a_sfr_exc: assert property (p_sfr_exc) else $error("denied register access without exception");

	property p_test_bl_exec;
		@(posedge clk_i) disable iff (rst_i)
			(mreq_i.valid && mode_ff == MODE_TEST && mreq_i.op == OP_EX && r_rombl) |=> mem_exc_o;
	endproperty
	a_test_bl_exec: assert property (p_test_bl_exec) else $error("bootloader executed in test mode");

	property p_wo_once;
		@(posedge clk_i) disable iff (rst_i)
			(mgo && mreq_i.op == OP_WO && m_uwo) |=> uwo_done_ff[$past(moff[4:0])];
	endproperty
	a_wo_once: assert property (p_wo_once) else $error("write-once mark not set");

	property p_prot;
		@(posedge clk_i) disable iff (rst_i)
			(mreq_i.valid && mreq_i.op == OP_PW && r_mfg && prot_bit) |=> (mem_exc_o && !mout_o.valid);
	endproperty
	a_prot: assert property (p_prot) else $error("protected byte written");

	property p_boot_rom;
		@(posedge clk_i) disable iff (rst_i)
			(mreq_i.valid && mode_ff == MODE_BOOT && mreq_i.op == OP_RD && r_rom && !r_rombl) |=> mout_o.valid;
	endproperty
	a_boot_rom: assert property (p_boot_rom) else $error("boot ROM read refused");

	property p_user_hw;
		@(posedge clk_i) disable iff (rst_i)
			(sreq_i.valid && is_user && g_hw && !seg_hw_ff[act_ff][sreq_i.hw_idx]) |=> sfr_exc_o;
	endproperty
	a_user_hw: assert property (p_user_hw) else $error("user hardware register not gated by segment");
endmodule

// *** rtl/mbac_consts.svh ***
`ifndef MBAC_CONSTS_SVH
`define MBAC_CONSTS_SVH
// Physical memory map.
`define MBAC_ROM_LO 24'h00_0000
`define MBAC_ROM_HI 24'h00_FFFF
`define MBAC_ROMFW_LO 24'h00_8000
`define MBAC_ROMFW_HI 24'h00_EFFF
`define MBAC_ROMBL_LO 24'h00_F000
`define MBAC_SFL_LO 24'h10_0000
`define MBAC_SFL_HI 24'h11_FFFF
`define MBAC_AFL_LO 24'h20_0000
`define MBAC_AFLROM_HI 24'h27_FFFF
`define MBAC_AFL_HI 24'h2F_FFFF
`define MBAC_FEE_LO 24'h40_0000
`define MBAC_FEE_HI 24'h40_0FFF
`define MBAC_AEE_LO 24'h40_1000
`define MBAC_AEE_HI 24'h41_FFFF
`define MBAC_MFG_LO 24'h41_FF00
`define MBAC_FRA_LO 24'h80_0000
`define MBAC_FRA_HI 24'h80_0FFF
`define MBAC_ARA_LO 24'h80_1000
`define MBAC_ARA_HI 24'h80_FFFF
// Sub-areas of the manufacturer area, as byte offsets from its base.
`define MBAC_M_UWP 8'h20
`define MBAC_M_UWO 8'h40
`define MBAC_M_VWP 8'h60
`define MBAC_M_BL 8'h80
`define MBAC_M_FUS 8'hC0
`define MBAC_M_PRB 8'hE0
`define MBAC_M_NOWR 8'h5C
`define MBAC_M_VNIB 8'h7F
// Register byte offsets.
`define MBAC_REG_MODE 8'h00
`define MBAC_REG_FWCTRL 8'h04
`define MBAC_REG_FMACC 8'h08
`define MBAC_REG_SEGSEL 8'h0C
`define MBAC_REG_SEGRT 8'h10
`define MBAC_REG_SEGLO 8'h14
`define MBAC_REG_SEGHI 8'h18
`define MBAC_REG_SEGOF 8'h1C
`define MBAC_REG_STAT 8'h20
// Field positions and reset values.
`define MBAC_FM_VFZ 0
`define MBAC_FM_VFP 1
`define MBAC_FM_VEZ 2
`define MBAC_RT_RW 0
`define MBAC_RT_X 1
`define MBAC_STAT_DENY 9
`define MBAC_FWCTRL_RST 16'h0000
`define MBAC_FMACC_RST 3'h0
`endif

// *** rtl/mbac_pkg.sv ***
package mbac_pkg;
	typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_FW, MODE_SYS, MODE_USER} mbac_mode_e;
	typedef enum logic [2:0] {OP_RD, OP_WR, OP_EX, OP_WO, OP_PW, OP_VFZ, OP_VFP, OP_VEZ} mbac_op_e;
	typedef enum logic [3:0] {GRP_MMU, GRP_SYS, GRP_FWCFG, GRP_FWOS, GRP_TEST, GRP_TESTONLY, GRP_HW, GRP_CPU,
		GRP_CPUSPLIT} mbac_grp_e;
	typedef struct packed {
		logic valid;
		mbac_op_e op;
		logic [23:0] vaddr;
		logic [7:0] wdata;
	} mbac_mreq_s;
	typedef struct packed {
		logic valid;
		mbac_op_e op;
		logic [23:0] paddr;
		logic [7:0] wdata;
		logic nib_only;
	} mbac_mout_s;
	typedef struct packed {
		logic valid;
		logic write;
		mbac_grp_e grp;
		logic [3:0] hw_idx;
	} mbac_sreq_s;
endpackage

// *** sim/mbac_cpu_model.sv ***
`timescale 1ns/1ps
module mbac_cpu_model (
	input wire logic clk_i, // System clock.
	output mbac_pkg::mbac_mreq_s mreq_o, // Memory request to the checker.
	output mbac_pkg::mbac_sreq_s sreq_o, // Register request to the checker.
	input wire mbac_pkg::mbac_mout_s mout_i, // Forwarded memory request.
	input wire logic mem_exc_i, // Memory exception.
	input wire logic sfr_ok_i, // Register grant.
	input wire logic sfr_exc_i // Register exception.
);
	import mbac_pkg::*;
	initial begin
		mreq_o = '0;
		sreq_o = '0;
	end
	// Idle lines carry inverted values, so a checker that looks past valid sees garbage, not the last request.
	task automatic mem(input logic [2:0] op, input logic [23:0] a, input logic [7:0] d, output logic ok,
		output logic exc, output mbac_mout_s o);
		@(posedge clk_i);
		mreq_o <= '{1'b1, mbac_op_e'(op), a, d};
		@(posedge clk_i);
		mreq_o <= '{1'b0, mbac_op_e'(~op), ~a, ~d};
		@(negedge clk_i);
		ok = mout_i.valid;
		exc = mem_exc_i;
		o = mout_i;
	endtask
	task automatic sfr(input logic w, input logic [3:0] g, input logic [3:0] idx, output logic ok, output logic exc);
		@(posedge clk_i);
		sreq_o <= '{1'b1, w, mbac_grp_e'(g), idx};
		@(posedge clk_i);
		sreq_o <= '{1'b0, ~w, mbac_grp_e'(~g), ~idx};
		@(negedge clk_i);
		ok = sfr_ok_i;
		exc = sfr_exc_i;
	endtask
endmodule

// *** sim/mode_based_access_control_tb.sv ***
`timescale 1ns/1ps
`include "mbac_consts.svh"
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("mismatch %s expected %0h seen %0h", nm, e, g); \
	end \
end
module mode_based_access_control_tb;
	import mbac_pkg::*;
	typedef struct packed {logic [2:0] md; logic sfr; logic [2:0] op; logic [23:0] a; logic ok; logic nib;} mbac_row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'hF;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	mbac_mreq_s mreq;
	mbac_mout_s mout;
	mbac_sreq_s sreq;
	logic mem_exc;
	logic sfr_ok;
	logic sfr_exc;
	int num_errors = 0;
	int n_compared = 0;
	// Sub-region rows run in mode order because user mode cannot be left without a reset.
	mbac_row_s rows[$] = '{
		'{3'h0,1'b0,3'h0,24'h00_0000,1'b1,1'b0},
		'{3'h0,1'b0,3'h2,24'h00_F000,1'b0,1'b0},
		'{3'h0,1'b0,3'h2,24'h10_0000,1'b1,1'b0},
		'{3'h0,1'b0,3'h1,24'h10_0000,1'b1,1'b0},
		'{3'h0,1'b0,3'h1,24'h40_0000,1'b1,1'b0},
		'{3'h0,1'b0,3'h1,24'h41_FFE4,1'b1,1'b0},
		'{3'h0,1'b0,3'h2,24'h41_FF80,1'b1,1'b0},
		'{3'h0,1'b0,3'h2,24'h80_0000,1'b1,1'b0},
		'{3'h0,1'b1,3'h0,24'h00_0000,1'b0,1'b0},
		'{3'h0,1'b1,3'h0,24'h00_0010,1'b1,1'b0},
		'{3'h0,1'b1,3'h0,24'h00_0050,1'b0,1'b0},
		'{3'h1,1'b0,3'h0,24'h00_F000,1'b1,1'b0},
		'{3'h1,1'b0,3'h2,24'h00_F000,1'b0,1'b0},
		'{3'h1,1'b0,3'h1,24'h20_0000,1'b1,1'b0},
		'{3'h1,1'b0,3'h2,24'h40_1000,1'b1,1'b0},
		'{3'h1,1'b0,3'h1,24'h80_1000,1'b1,1'b0},
		'{3'h1,1'b1,3'h0,24'h00_0050,1'b1,1'b0},
		'{3'h1,1'b1,3'h0,24'h00_0080,1'b0,1'b0},
		'{3'h2,1'b0,3'h2,24'h00_8000,1'b1,1'b0},
		'{3'h2,1'b0,3'h1,24'h10_0000,1'b1,1'b0},
		'{3'h2,1'b0,3'h2,24'h80_0000,1'b1,1'b0},
		'{3'h2,1'b0,3'h3,24'h41_FF41,1'b1,1'b0},
		'{3'h2,1'b0,3'h4,24'h41_FF60,1'b1,1'b0},
		'{3'h2,1'b0,3'h1,24'h41_FF80,1'b1,1'b0},
		'{3'h2,1'b0,3'h5,24'h20_0000,1'b1,1'b0},
		'{3'h2,1'b0,3'h6,24'h20_0000,1'b0,1'b0},
		'{3'h2,1'b0,3'h7,24'h40_1000,1'b1,1'b0},
		'{3'h2,1'b1,3'h0,24'h00_0020,1'b1,1'b0},
		'{3'h2,1'b1,3'h1,24'h00_0020,1'b0,1'b0},
		'{3'h2,1'b1,3'h0,24'h00_0062,1'b1,1'b0},
		'{3'h2,1'b1,3'h0,24'h00_0063,1'b0,1'b0},
		'{3'h3,1'b0,3'h2,24'h20_0000,1'b1,1'b0},
		'{3'h3,1'b0,3'h1,24'h20_0000,1'b0,1'b0},
		'{3'h3,1'b0,3'h0,24'h28_0000,1'b1,1'b0},
		'{3'h3,1'b0,3'h1,24'h28_0000,1'b1,1'b0},
		'{3'h3,1'b0,3'h0,24'h10_0000,1'b0,1'b0},
		'{3'h3,1'b0,3'h1,24'h10_0000,1'b0,1'b0},
		'{3'h3,1'b0,3'h1,24'h40_1000,1'b1,1'b0},
		'{3'h3,1'b0,3'h2,24'h80_FFFF,1'b1,1'b0},
		'{3'h3,1'b0,3'h1,24'h41_FF00,1'b0,1'b0},
		'{3'h3,1'b0,3'h1,24'h41_FF21,1'b0,1'b0},
		'{3'h3,1'b0,3'h4,24'h41_FF21,1'b1,1'b0},
		'{3'h3,1'b0,3'h4,24'h41_FF20,1'b0,1'b0},
		'{3'h3,1'b0,3'h3,24'h41_FF42,1'b1,1'b0},
		'{3'h3,1'b0,3'h3,24'h41_FF42,1'b0,1'b0},
		'{3'h3,1'b0,3'h3,24'h41_FF5C,1'b0,1'b0},
		'{3'h3,1'b0,3'h1,24'h41_FF60,1'b0,1'b0},
		'{3'h3,1'b0,3'h4,24'h41_FF61,1'b0,1'b0},
		'{3'h3,1'b0,3'h4,24'h41_FF7F,1'b1,1'b1},
		'{3'h3,1'b1,3'h1,24'h00_0000,1'b1,1'b0},
		'{3'h3,1'b1,3'h0,24'h00_0030,1'b0,1'b0}
	};
	always #5 clk = ~clk;
	mbac_checker #(.SEGS(4)) u_mbac_checker (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mreq_i(mreq), .mout_o(mout), .mem_exc_o(mem_exc), .sreq_i(sreq),
		.sfr_ok_o(sfr_ok), .sfr_exc_o(sfr_exc));
	mbac_cpu_model u_mbac_cpu_model (.clk_i(clk), .mreq_o(mreq), .sreq_o(sreq), .mout_i(mout),
		.mem_exc_i(mem_exc), .sfr_ok_i(sfr_ok), .sfr_exc_i(sfr_exc));
	task automatic test_done();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			$display("mismatch wb_ack expected 1 seen 0");
			test_done();
		end
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e, input string nm);
		logic [31:0] q;
		wb(1'b0, adr, 32'h0000_0000, q);
		`CHK(nm, e, q)
	endtask
	initial begin
		logic ok;
		logic exc;
		mbac_mout_s o;
		logic [2:0] cur;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		wr(`MBAC_REG_FWCTRL, 32'h0000_FFFF);
		rd_chk(`MBAC_REG_FWCTRL, 32'h0000_0000, "fwctrl_boot");
		wr(`MBAC_REG_MODE, 32'h0000_0003);
		wr(`MBAC_REG_FWCTRL, 32'h0000_0004);
		wr(`MBAC_REG_FMACC, 32'h0000_0005);
		rd_chk(`MBAC_REG_FWCTRL, 32'h0000_0004, "fwctrl");
		rd_chk(`MBAC_REG_FMACC, 32'h0000_0005, "fmacc");
		rd_chk(8'h30, 32'h0000_0000, "unmapped");
		cur = 3'h3;
		foreach (rows[i]) begin
			if (rows[i].md !== cur) begin
				wr(`MBAC_REG_MODE, {29'h0000_0000, rows[i].md});
				cur = rows[i].md;
			end
			if (rows[i].sfr) begin
				u_mbac_cpu_model.sfr(rows[i].op[0], rows[i].a[7:4], rows[i].a[3:0], ok, exc);
			end else begin
				u_mbac_cpu_model.mem(rows[i].op, rows[i].a, 8'h01, ok, exc, o);
			end
			`CHK("grant", rows[i].ok, ok)
			`CHK("exception", ~rows[i].ok, exc)
			if (!rows[i].sfr && rows[i].ok) begin
				`CHK("paddr", rows[i].a, o.paddr)
				`CHK("nib_only", rows[i].nib, o.nib_only)
				`CHK("op", rows[i].op, o.op)
				`CHK("wdata", 8'h01, o.wdata)
			end
		end
		// Segment 0 maps virtual 001000 onto application RAM; segment 1 has no rights at all.
		wr(`MBAC_REG_SEGSEL, 32'h0000_0000);
		wr(`MBAC_REG_SEGRT, 32'h0004_0003);
		wr(`MBAC_REG_SEGLO, 32'h0000_1000);
		wr(`MBAC_REG_SEGHI, 32'h0000_1FFF);
		wr(`MBAC_REG_SEGOF, 32'h0080_0000);
		wr(`MBAC_REG_SEGSEL, 32'h0000_0001);
		wr(`MBAC_REG_SEGRT, 32'h0000_0000);
		wr(`MBAC_REG_SEGLO, 32'h0000_2000);
		wr(`MBAC_REG_SEGHI, 32'h0000_2FFF);
		wr(`MBAC_REG_SEGOF, 32'h0080_0000);
		wr(`MBAC_REG_MODE, 32'h0000_0004);
		u_mbac_cpu_model.mem(3'h2, 24'h00_1010, 8'h01, ok, exc, o);
		`CHK("user_grant", 1'b1, ok)
		`CHK("user_paddr", 24'h80_1010, o.paddr)
		u_mbac_cpu_model.mem(3'h0, 24'h00_2010, 8'h01, ok, exc, o);
		`CHK("disabled_seg", 1'b0, ok)
		`CHK("disabled_exc", 1'b1, exc)
		u_mbac_cpu_model.sfr(1'b0, 4'h6, 4'h2, ok, exc);
		`CHK("user_hw_ok", 1'b1, ok)
		u_mbac_cpu_model.sfr(1'b1, 4'h6, 4'h3, ok, exc);
		`CHK("user_hw_exc", 1'b1, exc)
		u_mbac_cpu_model.sfr(1'b1, 4'h1, 4'h0, ok, exc);
		`CHK("user_sys_exc", 1'b1, exc)
		wr(`MBAC_REG_MODE, 32'h0000_0003);
		rd_chk(`MBAC_REG_MODE, 32'h0000_0004, "mode_locked");
		rd_chk(`MBAC_REG_STAT, 32'h0000_0204, "stat");
		wr(`MBAC_REG_STAT, 32'h0000_0200);
		rd_chk(`MBAC_REG_STAT, 32'h0000_0004, "stat_clear");
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("reset_mout", 1'b0, mout.valid)
		rd_chk(`MBAC_REG_MODE, 32'h0000_0000, "reset_mode");
		rd_chk(`MBAC_REG_FWCTRL, 32'h0000_0000, "reset_fwctrl");
		test_done();
	end
endmodule
